// >>> common/fhbf_defines.svh
// constants for the nibble bus framing target
// Function
// RULE1 - host holds bus reset at least 1 ms after supply is stable
// RULE2 - host holds bus reset at least 100 us after clock is stable
// RULE3 - any reset or restart pulse lasts at least 100 ns
// RULE4 - on reset the device floats the nibble bus within 48 ns
// RULE5 - reset during program or erase completes 20 us later
// RULE6 - four two-way nibble lines plus one framing input
// RULE7 - start cycle uses a reserved code other peripherals ignore
// RULE8 - all information moves as 4-bit fields on the nibble lines
// RULE9 - field length depends on field type, tracked per field
// RULE10 - read and write fields follow one fixed order
// RULE11 - host translates system addresses into device-local addresses
// RULE12 - only single-byte transfers, size field must be 0000
// RULE13 - start 1101 reads, 1110 writes, last start before frame rises
// RULE14 - select nibble must equal the strap select pins
// RULE15 - 28-bit address in seven nibbles msb first, then size
// RULE16 - read: turnaround, wait syncs, ready sync, data low nibble first
// RULE17 - reset drops any partial transaction; wait for new start
`ifndef FHBF_DEFINES_SVH
`define FHBF_DEFINES_SVH

// ----------------------------------------------------------------
// field codes
// ----------------------------------------------------------------
`define FHBF_START_RD 4'hd
`define FHBF_START_WR 4'he
`define FHBF_SIZE_ONE 4'h0
`define FHBF_WAIT_SYNC_CODE 4'h5
`define FHBF_READY_SYNC_CODE 4'h0
`define FHBF_TAR 4'hf
`define FHBF_NIB_LAST 3'h6
`define FHBF_CNT_ZERO 3'h0
`define FHBF_CNT_ONE 3'h1
`define FHBF_WAIT_DEF 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FHBF_CLK_NS 4
`define FHBF_PWR_MS 1
`define FHBF_CLKSTAB_US 100
`define FHBF_PULSE_NS 100
`define FHBF_FLOAT_NS 48
`define FHBF_FLOAT_CYC (`FHBF_FLOAT_NS / `FHBF_CLK_NS)
`define FHBF_LAT_US 20
`define FHBF_LAT_CYC (`FHBF_LAT_US * 1000 / `FHBF_CLK_NS)

`endif

// >>> common/fhbf_pkg.sv
// types for the nibble bus framing target
package fhbf_pkg;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_SEL,
    ST_ADDR,
    ST_SIZE,
    ST_WDATA,
    ST_HTAR,
    ST_WAIT,
    ST_READY_SYNC_CODE,
    ST_RDATA,
    ST_DTAR
  } fhbf_state_t;
endpackage

// >>> verilog/fhbf_target.sv
// nibble bus framing target with reset sequencing
`timescale 1ns/1ps
`default_nettype none
`include "fhbf_defines.svh"

module fhbf_target #(
  parameter int WAIT_CNT = `FHBF_WAIT_DEF,
  parameter int RESET_LAT_CYC = `FHBF_LAT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic bus_reset_n,
  input wire logic frame_control_in_n,
  input wire logic [3:0] nibble_bus_in,
  output logic [3:0] nibble_bus_out,
  output logic nibble_bus_oe,
  input wire logic [3:0] strap_select_pins,
  input wire logic op_busy,
  output logic dev_ready,
  output logic mem_rd_req,
  output logic mem_wr_req,
  output logic [27:0] mem_addr,
  output logic [7:0] mem_wr_data,
  input wire logic [7:0] mem_rd_data
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  localparam int FLOAT_CYC = `FHBF_FLOAT_CYC;
  generate
    if (WAIT_CNT < 1 || WAIT_CNT > 7) begin : g_bad_wait
      $error("wait count must lie in 1..7");
    end
    if (RESET_LAT_CYC < 1 || RESET_LAT_CYC > 65535) begin : g_bad_lat
      $error("reset latency must lie in 1..65535");
    end
    if (FLOAT_CYC < 1) begin : g_bad_float
      $error("float bound below one cycle");
    end
  endgenerate

  // ----------------------------------------------------------------
  // reset latency
  // ----------------------------------------------------------------
  logic [15:0] lat_cnt_ff;
  logic bus_rst_q_ff;
  logic link_ok;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rst_q_ff <= 1'b1;
    end else begin
      bus_rst_q_ff <= bus_reset_n;
    end
  end

  // core needs time to stop a program or erase safely
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_cnt_ff <= 16'h0000;
    end else if (bus_rst_q_ff && !bus_reset_n && op_busy) begin
      lat_cnt_ff <= 16'(RESET_LAT_CYC); // RULE5
    end else if (lat_cnt_ff != 16'h0000) begin
      lat_cnt_ff <= lat_cnt_ff - 16'h0001;
    end
  end

  assign dev_ready = bus_reset_n && (lat_cnt_ff == 16'h0000); // RULE5
  assign link_ok = dev_ready;

  // ----------------------------------------------------------------
  // field sequencer
  // ----------------------------------------------------------------
  fhbf_pkg::fhbf_state_t state_ff;
  logic [2:0] cnt_ff;
  logic is_wr_ff;
  logic [27:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] rdbyte_ff;
  logic [3:0] out_ff;
  logic oe_ff;
  logic rd_req_ff;
  logic wr_req_ff;
  logic is_start;

  assign is_start = (nibble_bus_in == `FHBF_START_RD) ||
                    (nibble_bus_in == `FHBF_START_WR); // RULE7

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= fhbf_pkg::ST_IDLE;
      cnt_ff <= `FHBF_CNT_ZERO;
      is_wr_ff <= 1'b0;
      addr_ff <= 28'h0000000;
      wdata_ff <= 8'h00;
      rdbyte_ff <= 8'h00;
      out_ff <= 4'h0;
      oe_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      wr_req_ff <= 1'b0;
    end else begin
      rd_req_ff <= 1'b0;
      wr_req_ff <= 1'b0;
      if (!link_ok) begin
        state_ff <= fhbf_pkg::ST_IDLE; // RULE17
        oe_ff <= 1'b0; // RULE4
        cnt_ff <= `FHBF_CNT_ZERO;
      end else if (!frame_control_in_n) begin
        // only the last start before frame rises counts
        oe_ff <= 1'b0;
        cnt_ff <= `FHBF_CNT_ZERO;
        state_ff <= is_start ? fhbf_pkg::ST_SEL : fhbf_pkg::ST_IDLE; // RULE13
        is_wr_ff <= (nibble_bus_in == `FHBF_START_WR); // RULE13
      end else begin
        case (state_ff)
          fhbf_pkg::ST_SEL: begin
            state_ff <= (nibble_bus_in == strap_select_pins) ?
                        fhbf_pkg::ST_ADDR : fhbf_pkg::ST_IDLE; // RULE14
          end
          fhbf_pkg::ST_ADDR: begin
            addr_ff <= {addr_ff[23:0], nibble_bus_in}; // RULE15
            cnt_ff <= cnt_ff + `FHBF_CNT_ONE;
            if (cnt_ff == `FHBF_NIB_LAST) begin
              state_ff <= fhbf_pkg::ST_SIZE; // RULE15
              cnt_ff <= `FHBF_CNT_ZERO;
            end
          end
          fhbf_pkg::ST_SIZE: begin
            // multibyte sizes are left unanswered
            if (nibble_bus_in != `FHBF_SIZE_ONE) begin
              state_ff <= fhbf_pkg::ST_IDLE; // RULE12
            end else if (is_wr_ff) begin
              state_ff <= fhbf_pkg::ST_WDATA; // RULE10
            end else begin
              rd_req_ff <= 1'b1;
              state_ff <= fhbf_pkg::ST_HTAR; // RULE10
            end
          end
          fhbf_pkg::ST_WDATA: begin
            if (cnt_ff == `FHBF_CNT_ZERO) begin
              wdata_ff[3:0] <= nibble_bus_in; // RULE8
              cnt_ff <= `FHBF_CNT_ONE;
            end else begin
              wdata_ff[7:4] <= nibble_bus_in; // RULE8
              wr_req_ff <= 1'b1;
              cnt_ff <= `FHBF_CNT_ZERO;
              state_ff <= fhbf_pkg::ST_HTAR;
            end
          end
          fhbf_pkg::ST_HTAR: begin
            if (cnt_ff == `FHBF_CNT_ZERO) begin
              cnt_ff <= `FHBF_CNT_ONE; // RULE9
            end else begin
              oe_ff <= 1'b1; // RULE16
              cnt_ff <= `FHBF_CNT_ZERO;
              if (is_wr_ff) begin
                out_ff <= `FHBF_READY_SYNC_CODE;
                state_ff <= fhbf_pkg::ST_READY_SYNC_CODE;
              end else begin
                out_ff <= `FHBF_WAIT_SYNC_CODE; // RULE16
                state_ff <= fhbf_pkg::ST_WAIT;
              end
            end
          end
          fhbf_pkg::ST_WAIT: begin
            if (cnt_ff == 3'(WAIT_CNT - 1)) begin
              // memory must answer within the wait syncs
              rdbyte_ff <= mem_rd_data;
              out_ff <= `FHBF_READY_SYNC_CODE; // RULE16
              cnt_ff <= `FHBF_CNT_ZERO;
              state_ff <= fhbf_pkg::ST_READY_SYNC_CODE;
            end else begin
              cnt_ff <= cnt_ff + `FHBF_CNT_ONE; // RULE9
            end
          end
          fhbf_pkg::ST_READY_SYNC_CODE: begin
            if (is_wr_ff) begin
              out_ff <= `FHBF_TAR;
              state_ff <= fhbf_pkg::ST_DTAR;
            end else begin
              out_ff <= rdbyte_ff[3:0]; // RULE16
              state_ff <= fhbf_pkg::ST_RDATA;
            end
          end
          fhbf_pkg::ST_RDATA: begin
            if (cnt_ff == `FHBF_CNT_ZERO) begin
              out_ff <= rdbyte_ff[7:4]; // RULE16
              cnt_ff <= `FHBF_CNT_ONE;
            end else begin
              out_ff <= `FHBF_TAR;
              cnt_ff <= `FHBF_CNT_ZERO;
              state_ff <= fhbf_pkg::ST_DTAR;
            end
          end
          fhbf_pkg::ST_DTAR: begin
            if (cnt_ff == `FHBF_CNT_ZERO) begin
              oe_ff <= 1'b0; // RULE16
              cnt_ff <= `FHBF_CNT_ONE;
            end else begin
              cnt_ff <= `FHBF_CNT_ZERO;
              state_ff <= fhbf_pkg::ST_IDLE;
            end
          end
          default: begin
            state_ff <= fhbf_pkg::ST_IDLE;
            oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // gating by the pin itself floats well inside the 48 ns bound
  assign nibble_bus_oe = oe_ff && bus_reset_n; // RULE4 RULE6
  assign nibble_bus_out = out_ff;
  assign mem_rd_req = rd_req_ff;
  assign mem_wr_req = wr_req_ff;
  assign mem_addr = addr_ff;
  assign mem_wr_data = wdata_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_float;
    @(posedge sys_clk) disable iff (!rst_n)
      !bus_reset_n |-> !nibble_bus_oe;
  endproperty
  a_float: assert property (p_float) else $error("bus not floated"); // RULE4

  property p_latency;
    @(posedge sys_clk) disable iff (!rst_n)
      (bus_rst_q_ff && !bus_reset_n && op_busy) |=> !dev_ready[*8];
  endproperty
  a_latency: assert property (p_latency) else $error("latency skipped"); // RULE5

  property p_abort;
    @(posedge sys_clk) disable iff (!rst_n)
      !bus_reset_n |=> (state_ff == fhbf_pkg::ST_IDLE) && !oe_ff;
  endproperty
  a_abort: assert property (p_abort) else $error("transfer survived reset"); // RULE17

  property p_start;
    @(posedge sys_clk) disable iff (!rst_n || !link_ok)
      (!frame_control_in_n && nibble_bus_in == `FHBF_START_RD)
      |=> state_ff == fhbf_pkg::ST_SEL && !is_wr_ff;
  endproperty
  a_start: assert property (p_start) else $error("read start missed"); // RULE13

  property p_select;
    @(posedge sys_clk) disable iff (!rst_n || !link_ok)
      (state_ff == fhbf_pkg::ST_SEL && frame_control_in_n &&
       nibble_bus_in != strap_select_pins) |=> state_ff == fhbf_pkg::ST_IDLE;
  endproperty
  a_select: assert property (p_select) else $error("foreign select taken"); // RULE14

  property p_addr;
    @(posedge sys_clk) disable iff (!rst_n || !link_ok || !frame_control_in_n)
      (state_ff == fhbf_pkg::ST_SEL && nibble_bus_in == strap_select_pins)
      |=> (state_ff == fhbf_pkg::ST_ADDR)[*7] ##1
          state_ff == fhbf_pkg::ST_SIZE;
  endproperty
  a_addr: assert property (p_addr) else $error("address length wrong"); // RULE15

  property p_size;
    @(posedge sys_clk) disable iff (!rst_n || !link_ok || !frame_control_in_n)
      (state_ff == fhbf_pkg::ST_SIZE && nibble_bus_in != `FHBF_SIZE_ONE)
      |=> state_ff == fhbf_pkg::ST_IDLE && !mem_rd_req;
  endproperty
  a_size: assert property (p_size) else $error("multibyte accepted"); // RULE12

  property p_first_sync;
    @(posedge sys_clk) disable iff (!rst_n || !link_ok)
      $rose(nibble_bus_oe) |->
        nibble_bus_out == (is_wr_ff ? `FHBF_READY_SYNC_CODE : `FHBF_WAIT_SYNC_CODE);
  endproperty
  a_first_sync: assert property (p_first_sync) else $error("bad sync"); // RULE16

  property p_rdata;
    @(posedge sys_clk) disable iff (!rst_n || !link_ok || !frame_control_in_n)
      (state_ff == fhbf_pkg::ST_READY_SYNC_CODE && !is_wr_ff) |=>
        nibble_bus_out == rdbyte_ff[3:0] ##1
        nibble_bus_out == rdbyte_ff[7:4] ##1
        nibble_bus_out == `FHBF_TAR && nibble_bus_oe ##1 !nibble_bus_oe;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data order"); // RULE16

  property p_wr_order;
    @(posedge sys_clk) disable iff (!rst_n)
      mem_wr_req |-> $past(state_ff) == fhbf_pkg::ST_WDATA;
  endproperty
  a_wr_order: assert property (p_wr_order) else $error("write out of order"); // RULE10

  c_read: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_ff == fhbf_pkg::ST_RDATA);
  c_write: cover property (@(posedge sys_clk) disable iff (!rst_n)
    mem_wr_req);
  c_latency: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(lat_cnt_ff != 16'h0000));

endmodule
`default_nettype wire

// >>> bench/fhbf_host_model.sv
// host side of the nibble bus: line resolution and release behaviour
`timescale 1ns/1ps
`default_nettype none
module fhbf_host_model (
  input wire logic sys_clk,
  input wire logic [3:0] host_val,
  input wire logic host_oe,
  input wire logic [3:0] nibble_bus_out,
  input wire logic nibble_bus_oe,
  output logic [3:0] bus_wire
);
  logic [3:0] last_ff = 4'h0;

  always_ff @(posedge sys_clk) begin
    last_ff <= bus_wire;
  end

  // no pull on the lines: a released bus toggles, never a stale copy
  always_comb begin
    if (nibble_bus_oe) begin
      bus_wire = nibble_bus_out;
    end else if (host_oe) begin
      bus_wire = host_val;
    end else begin
      bus_wire = ~last_ff;
    end
  end
endmodule
`default_nettype wire

// >>> bench/fhbf_target_tb_top.sv
// self-checking bench for the nibble bus framing target
`timescale 1ns/1ps
`default_nettype none
module fhbf_target_tb_top;
  // latency must outlast the 25-cycle reset pulse to be visible after it
  localparam int LAT = 40;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic bus_reset_n = 1'b0;
  logic frame_n = 1'b1;
  logic [3:0] host_val = 4'hf;
  logic host_oe = 1'b0;
  logic [3:0] strap = 4'h9;
  logic op_busy = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic [3:0] nib_out;
  logic [3:0] bus_wire;
  logic nib_oe, dev_ready, rd_req, wr_req;
  logic [27:0] mem_addr;
  logic [7:0] wr_data;
  int num_errors = 0;
  int checked = 0;

  fhbf_target #(.WAIT_CNT(2), .RESET_LAT_CYC(LAT)) fhbf_target_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_reset_n(bus_reset_n),
    .frame_control_in_n(frame_n), .nibble_bus_in(bus_wire),
    .nibble_bus_out(nib_out), .nibble_bus_oe(nib_oe),
    .strap_select_pins(strap), .op_busy(op_busy), .dev_ready(dev_ready),
    .mem_rd_req(rd_req), .mem_wr_req(wr_req), .mem_addr(mem_addr),
    .mem_wr_data(wr_data), .mem_rd_data(rd_data)
  );
  fhbf_host_model fhbf_host_model_inst (
    .sys_clk(sys_clk), .host_val(host_val), .host_oe(host_oe),
    .nibble_bus_out(nib_out), .nibble_bus_oe(nib_oe), .bus_wire(bus_wire)
  );

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (exp !== got) begin
      num_errors++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cyc(input logic [3:0] v, input logic fr, input logic oe);
    @(posedge sys_clk);
    host_val <= v;
    frame_n <= fr;
    host_oe <= oe;
  endtask

  // value on the wire only matters while the device drives
  task automatic dev(input logic [3:0] v, input logic oe);
    @(posedge sys_clk);
    #1;
    chk({oe, oe ? v : 4'h0}, {nib_oe, nib_oe ? bus_wire : 4'h0});
  endtask

  task automatic hdr(input logic [3:0] st, input logic [3:0] sel,
                     input logic [27:0] a, input logic [3:0] sz);
    cyc(st, 1'b0, 1'b1);
    cyc(sel, 1'b1, 1'b1);
    for (int i = 6; i >= 0; i--) begin
      cyc(a[i*4 +: 4], 1'b1, 1'b1);
    end
    cyc(sz, 1'b1, 1'b1);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic rd(input logic [27:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    rd_data <= d;
    hdr(4'hd, strap, a, 4'h0);
    cyc(4'hf, 1'b1, 1'b1);
    #1;
    chk({4'h1, a}, {3'h0, rd_req, mem_addr});
    cyc(4'hf, 1'b1, 1'b0);
    #1;
    chk(0, rd_req);
    dev(4'h5, 1'b1);
    dev(4'h5, 1'b1);
    dev(4'h0, 1'b1);
    dev(d[3:0], 1'b1);
    dev(d[7:4], 1'b1);
    dev(4'hf, 1'b1);
    dev(4'h0, 1'b0);
  endtask

  task automatic wr(input logic [27:0] a, input logic [7:0] d);
    hdr(4'he, strap, a, 4'h0);
    cyc(d[3:0], 1'b1, 1'b1);
    cyc(d[7:4], 1'b1, 1'b1);
    cyc(4'hf, 1'b1, 1'b1);
    #1;
    chk({1'b1, a}, {wr_req, mem_addr});
    chk(d, wr_data);
    cyc(4'hf, 1'b1, 1'b0);
    dev(4'h0, 1'b1);
    dev(4'hf, 1'b1);
    dev(4'h0, 1'b0);
  endtask

  task automatic sil(input logic [3:0] st, input logic [3:0] sel,
                     input logic [3:0] sz);
    hdr(st, sel, 28'h0000123, sz);
    cyc(4'hf, 1'b1, 1'b0);
    repeat (14) begin
      @(posedge sys_clk);
      #1;
      chk(0, {rd_req, wr_req, nib_oe});
    end
  endtask

  task automatic rst_mid();
    hdr(4'hd, strap, 28'h0abcdef, 4'h0);
    cyc(4'hf, 1'b1, 1'b1);
    cyc(4'hf, 1'b1, 1'b0);
    dev(4'h5, 1'b1);
    @(posedge sys_clk);
    bus_reset_n <= 1'b0;
    #1;
    chk(0, nib_oe);
    repeat (25) @(posedge sys_clk);
    bus_reset_n <= 1'b1;
    repeat (16) dev(4'h0, 1'b0);
    rd(28'h0abcdef, 8'h5a);
  endtask

  task automatic lat(input logic busy);
    int n;
    n = 0;
    @(posedge sys_clk);
    op_busy <= busy;
    @(posedge sys_clk);
    bus_reset_n <= 1'b0;
    repeat (25) @(posedge sys_clk);
    bus_reset_n <= 1'b1;
    op_busy <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(!busy, dev_ready);
    while (dev_ready !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(busy ? LAT - 25 : 0, n);
    if (n == 40) begin
      num_errors++;
      summarize();
    end
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    // power and clock settle waits scaled down to keep the run short
    repeat (25) @(posedge sys_clk);
    bus_reset_n <= 1'b1;
    rd(28'h0000001, 8'ha5);
    rd(28'hfedcba9, 8'h3c);
    wr(28'h8421357, 8'h96);
    cyc(4'he, 1'b0, 1'b1);
    rd(28'h7654321, 8'hc3);
    for (int c = 0; c < 16; c++) begin
      if (c != 13 && c != 14) begin
        sil(c[3:0], strap, 4'h0);
      end
    end
    sil(4'hd, ~strap, 4'h0);
    sil(4'he, ~strap, 4'h0);
    sil(4'hd, strap, 4'h1);
    rst_mid();
    lat(1'b0);
    lat(1'b1);
    wr(28'h0000abc, 8'h01);
    summarize();
  end
endmodule
`default_nettype wire
